//--- logic/pjt_pkg.sv
package pjt_pkg;

  // ==========================================================================
  // Timing.
  localparam int CORE_PERIOD_NS = 50;
  localparam int CORE_KHZ       = 20000;
  localparam int LINE_KHZ       = 2048;
  localparam int CLK_LOSS_NS    = 2000;
  localparam int CLK_LOSS_CYC   = (CLK_LOSS_NS / CORE_PERIOD_NS < 1) ? 1 :
                                  CLK_LOSS_NS / CORE_PERIOD_NS;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_EVEN_TX   = 8'h00;
  localparam logic [7:0] OFS_ODD_TX    = 8'h04;
  localparam logic [7:0] OFS_EVEN_TEST = 8'h08;
  localparam logic [7:0] OFS_ODD_TEST  = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_LOOP      = 8'h14;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RST_EVEN_TX   = 8'h9b;
  localparam logic [7:0] RST_ODD_TX    = 8'hdf;
  localparam logic [7:0] RST_TEST      = 8'h00;

  // ==========================================================================
  // Slot zero field positions, first bit on the line is bit 7.
  localparam int POS_SPARE_BIT = 7;
  localparam int POS_ODD_FIXED = 6;
  localparam int POS_ODD_ALARM = 5;

  // Status bit positions.
  localparam int ST_REMOTE_LOSS = 0;
  localparam int ST_LOCAL_LOSS  = 1;
  localparam int ST_CLK_ABSENT  = 2;
  localparam int ST_DESYNC      = 3;
  localparam int ST_RAI         = 4;
  localparam int ST_EXCESS_ERR  = 5;
  localparam int ST_LEAD        = 6;
  localparam int ST_SLIP        = 7;

  // ==========================================================================
  // Framing.
  localparam logic [6:0] FAS_WORD       = 7'h1b;
  localparam logic [7:0] TS0_LAST_BIT   = 8'h07;
  localparam logic [7:0] PHASE_BIT      = 8'h04;
  localparam logic [7:0] FRAME_LAST_BIT = 8'hff;
  localparam logic [7:0] HUNT_RESUME    = 8'h08;
  localparam logic [1:0] FAS_MISS_LIMIT = 2'h2;
  localparam logic [9:0] ERR_WINDOW     = 10'h3e7;
  localparam logic [12:0] ERR_LIMIT     = 13'h0007;
  localparam logic [1:0] RAI_FRAMES     = 2'h2;

  // Line code symbol kinds.
  localparam logic [1:0] K_NONE = 2'h0;
  localparam logic [1:0] K_MARK = 2'h1;
  localparam logic [1:0] K_FILL = 2'h2;
  localparam logic [1:0] K_VIOL = 2'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    ALIGN_HUNT,
    ALIGN_CHECK_NFAS,
    ALIGN_CHECK_FAS,
    ALIGN_LOCKED
  } pjt_align_t;

  typedef struct packed {
    logic recoveredRemoteClock;
    logic rxRailPositive;
    logic rxRailNegative;
  } pjt_line_t;

  typedef struct packed {
    logic rxData;
    logic bitStrobe;
    logic frameStart;
  } pjt_mux_t;

endpackage

//--- logic/pjt_sync2.sv
`timescale 1ns/1ps
module pjt_sync2 import pjt_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  // Data.
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1Reg;

  // ==========================================================================
  // Two flip-flop synchroniser.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1Reg <= '0;
      syncOut   <= '0;
    end else if (clkEn) begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule

//--- logic/pjt_hdb3_encoder.sv
`timescale 1ns/1ps
module pjt_hdb3_encoder import pjt_pkg::*; (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  // Bit stream.
  input  wire logic bitStrobe,
  input  wire logic hdb3En,
  input  wire logic dataIn,
  // Rails.
  output logic      railPos,
  output logic      railNeg
);

  logic [3:0][1:0] kindReg;
  logic            parityReg;
  logic            lastPolReg;
  logic [3:0][1:0] kindNext;
  logic            pulse;
  logic            pol;

  // ==========================================================================
  // Four zeros become a fill sequence with a violation.
  always_comb begin
    kindNext = {kindReg[2:0], (dataIn ? K_MARK : K_NONE)};
    if (!dataIn && kindReg[2:0] == '0) begin
      kindNext[0] = K_VIOL;
      kindNext[3] = parityReg ? K_NONE : K_FILL;
    end
    pulse = kindReg[3] != K_NONE;
    pol   = (kindReg[3] == K_VIOL) ? lastPolReg : !lastPolReg;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kindReg    <= '0;
      parityReg  <= 1'b0;
      lastPolReg <= 1'b0;
      railPos    <= 1'b0;
      railNeg    <= 1'b0;
    end else if (clkEn && bitStrobe) begin
      if (hdb3En) begin
        kindReg   <= kindNext;
        parityReg <= (kindNext[0] == K_VIOL) ? 1'b0 : parityReg ^ dataIn;
        if (pulse) begin
          lastPolReg <= pol;
        end
        railPos <= pulse && pol;
        railNeg <= pulse && !pol;
      end else begin
        railPos <= dataIn;
        railNeg <= 1'b0;
      end
    end
  end

endmodule

//--- logic/pjt_junction_unit.sv
// What this block does
// - Receive stream realigned to local frame timing.
// - Frame memory slips whole frames on drift.
// - Strap low: alarm OR sent in odd bit 3.
// - Strap high: processor reaches six registers.
// - Even transmit register: only bit 1 writable.
// - Odd transmit register bit 2 stays one.
// - Odd register bit 3 shows alarm OR.
// - Loop register is one test bit.
// - Loop off: normal registers, line input used.
// - Loop on: test values both directions.
// - Status register written only by receiver.
// - Status bit 1 copies remote alarm bit.
// - Status bit 2 flags local alignment loss.
// - Status bit 3 flags missing receive clock.
// - Status bit 4 flags junction desynchronisation.
// - Status bit 5 is remote alarm indication.
// - Status bit 6 flags error ratio above 1e-3.
// - Status bit 7 shows local clock lead.
// - Status bit 8 flags each frame slip.
// - Receive logic acts on recovered clock fall.
// - Frame phase output toggles at slot bit 5.
// - Strap selects rail pairs or binary input.
// - Rail code uses fill sequences with violations.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pjt_junction_unit import pjt_pkg::*; (
  // Clock, reset and enable.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  // Register bus.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Straps.
  input  wire logic        cpuPortStrap,
  input  wire logic        binaryModeStrap,
  // Line side.
  input  wire pjt_line_t   lineIn,
  output logic             txRailPositive,
  output logic             txRailNegative,
  output logic             framePhase4kOut,
  // Local multiplex side.
  input  wire logic        txMuxData,
  output pjt_mux_t         localMux
);

  pjt_line_t     lineSync;
  logic [1:0]    strapSync;
  logic          cpuMode;
  logic          binMode;
  logic          rxClkDlyReg;
  logic          rxFall;
  logic          lastPolReg;
  logic [3:0]    decReg;
  logic          rxPulse;
  logic          rxViol;
  logic          rxBit;
  logic [7:0]    rxShiftReg;
  logic [7:0]    rxShiftNext;
  logic [7:0]    rxBitCntReg;
  logic          rxOddReg;
  logic          tsEnd;
  logic          fasOk;
  pjt_align_t    alignReg;
  logic [1:0]    fasMissReg;
  logic          remoteLossReg;
  logic [9:0]    errWordsReg;
  logic [12:0]   errBitsReg;
  logic [12:0]   errBitsNext;
  logic          excessErrReg;
  logic [1:0]    raiCntReg;
  logic          raiReg;
  logic [6:0]    lossCntReg;
  logic          clkAbsentReg;
  logic          desync;
  logic          alarmOr;
  logic          frameMem [0:1023];
  logic [1:0]    wrFrameReg;
  logic [1:0]    rdFrameReg;
  logic [1:0]    newest;
  logic [1:0]    rdFrameUse;
  logic [15:0]   phaseAccReg;
  logic [15:0]   phaseSum;
  logic          strobeNow;
  logic [7:0]    txBitCntReg;
  logic          txOddReg;
  logic          frameStart;
  logic          slot0;
  logic          slipEvent;
  logic          leadReg;
  logic          slipReg;
  logic [7:0]    evenTxReg;
  logic [7:0]    oddTxReg;
  logic [7:0]    evenTestReg;
  logic [7:0]    oddTestReg;
  logic          loopReg;
  logic [7:0]    oddEff;
  logic [7:0]    statusVal;
  logic [7:0]    txSlotVal;
  logic [7:0]    rxSlotVal;
  logic          txBitNow;
  logic          addrPhase;
  logic          wrPendReg;
  logic [7:0]    wrAddrReg;
  logic          statusRead;
  logic          rxDataReg;

  // ==========================================================================
  // Pin synchronisers.
  pjt_sync2 #(.WIDTH(3)) u_line_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .asyncIn  (lineIn),
    .syncOut  (lineSync)
  );

  pjt_sync2 #(.WIDTH(2)) u_strap_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .asyncIn  ({cpuPortStrap, binaryModeStrap}),
    .syncOut  (strapSync)
  );

  assign cpuMode = strapSync[1];
  assign binMode = strapSync[0];

  // Count of ones in a seven-bit word, used for the error ratio.
  function automatic logic [2:0] popCount7(input logic [6:0] v);
    logic [2:0] n;
    n = '0;
    for (int i = 0; i < 7; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  // ==========================================================================
  // Receive edge detect and line decoding.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxClkDlyReg <= 1'b0;
    end else if (clkEn) begin
      rxClkDlyReg <= lineSync.recoveredRemoteClock;
    end
  end

  assign rxFall  = rxClkDlyReg && !lineSync.recoveredRemoteClock;
  assign rxPulse = lineSync.rxRailPositive || lineSync.rxRailNegative;
  assign rxViol  = rxPulse && (lineSync.rxRailPositive == lastPolReg);
  assign rxBit   = binMode ? lineSync.rxRailPositive : decReg[3];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastPolReg <= 1'b0;
      decReg     <= '0;
    end else if (clkEn && rxFall) begin
      if (rxPulse) begin
        lastPolReg <= lineSync.rxRailPositive;
      end
      if (rxViol) begin
        decReg <= {1'b0, decReg[1:0], 1'b0};
      end else begin
        decReg <= {decReg[2:0], rxPulse};
      end
    end
  end

  // ==========================================================================
  // Frame alignment.
  assign rxShiftNext = {rxShiftReg[6:0], rxBit};
  assign tsEnd       = rxBitCntReg == TS0_LAST_BIT;
  assign fasOk       = rxShiftNext[6:0] == FAS_WORD;
  assign desync      = alignReg != ALIGN_LOCKED;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShiftReg    <= '0;
      rxBitCntReg   <= '0;
      rxOddReg      <= 1'b0;
      alignReg      <= ALIGN_HUNT;
      fasMissReg    <= '0;
      remoteLossReg <= 1'b0;
    end else if (clkEn && rxFall) begin
      rxShiftReg <= rxShiftNext;
      if (alignReg == ALIGN_HUNT && fasOk) begin
        rxBitCntReg <= HUNT_RESUME;
        rxOddReg    <= 1'b0;
      end else begin
        rxBitCntReg <= rxBitCntReg + 8'h01;
        if (rxBitCntReg == FRAME_LAST_BIT) begin
          rxOddReg <= !rxOddReg;
        end
      end
      case (alignReg)
        ALIGN_HUNT: begin
          if (fasOk) begin
            alignReg <= ALIGN_CHECK_NFAS;
          end
        end
        ALIGN_CHECK_NFAS: begin
          if (tsEnd && rxOddReg) begin
            alignReg <= rxShiftNext[POS_ODD_FIXED] ? ALIGN_CHECK_FAS : ALIGN_HUNT;
          end
        end
        ALIGN_CHECK_FAS: begin
          if (tsEnd && !rxOddReg) begin
            alignReg   <= fasOk ? ALIGN_LOCKED : ALIGN_HUNT;
            fasMissReg <= '0;
          end
        end
        ALIGN_LOCKED: begin
          if (tsEnd && !rxOddReg) begin
            if (fasOk) begin
              fasMissReg <= '0;
            end else if (fasMissReg == FAS_MISS_LIMIT) begin
              alignReg <= ALIGN_HUNT;
            end else begin
              fasMissReg <= fasMissReg + 2'h1;
            end
          end
          if (tsEnd && rxOddReg) begin
            remoteLossReg <= rxShiftNext[POS_ODD_ALARM];
          end
        end
        default: begin
          alignReg <= ALIGN_HUNT;
        end
      endcase
    end
  end

  // ==========================================================================
  // Error ratio, remote alarm indication and frame phase.
  assign errBitsNext = errBitsReg + {10'h000, popCount7(rxShiftNext[6:0] ^ FAS_WORD)};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      errWordsReg  <= '0;
      errBitsReg   <= '0;
      excessErrReg <= 1'b0;
    end else if (clkEn && rxFall && tsEnd && !rxOddReg && !desync) begin
      if (errWordsReg == ERR_WINDOW) begin
        excessErrReg <= errBitsNext > ERR_LIMIT;
        errWordsReg  <= '0;
        errBitsReg   <= '0;
      end else begin
        errWordsReg <= errWordsReg + 10'h001;
        errBitsReg  <= errBitsNext;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      raiCntReg <= '0;
      raiReg    <= 1'b0;
    end else if (clkEn) begin
      if (!desync) begin
        raiCntReg <= '0;
        raiReg    <= 1'b0;
      end else if (rxFall && rxBitCntReg == FRAME_LAST_BIT) begin
        if (raiCntReg == RAI_FRAMES) begin
          raiReg <= 1'b1;
        end else begin
          raiCntReg <= raiCntReg + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      framePhase4kOut <= 1'b0;
    end else if (clkEn && rxFall && rxBitCntReg == PHASE_BIT && alignReg != ALIGN_HUNT) begin
      framePhase4kOut <= !framePhase4kOut;
    end
  end

  // ==========================================================================
  // Missing receive clock.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lossCntReg   <= '0;
      clkAbsentReg <= 1'b0;
    end else if (clkEn) begin
      if (lineSync.recoveredRemoteClock != rxClkDlyReg) begin
        lossCntReg   <= '0;
        clkAbsentReg <= 1'b0;
      end else if (lossCntReg == 7'(CLK_LOSS_CYC)) begin
        clkAbsentReg <= 1'b1;
      end else begin
        lossCntReg <= lossCntReg + 7'h01;
      end
    end
  end

  assign alarmOr = desync || excessErrReg || clkAbsentReg;

  // ==========================================================================
  // Frame memory write side.
  always_ff @(posedge core_clk) begin
    if (clkEn && rxFall) begin
      frameMem[{wrFrameReg, rxBitCntReg}] <= rxBit;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrFrameReg <= '0;
    end else if (clkEn && rxFall && rxBitCntReg == FRAME_LAST_BIT) begin
      wrFrameReg <= wrFrameReg + 2'h1;
    end
  end

  // ==========================================================================
  // Local timing and frame memory read side.
  assign phaseSum   = phaseAccReg + 16'(LINE_KHZ);
  assign strobeNow  = phaseSum >= 16'(CORE_KHZ);
  assign frameStart = strobeNow && txBitCntReg == '0;
  assign slot0      = txBitCntReg <= TS0_LAST_BIT;
  assign newest     = wrFrameReg - 2'h1;
  assign slipEvent  = frameStart && newest != rdFrameReg + 2'h1;
  assign rdFrameUse = frameStart ? newest : rdFrameReg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseAccReg <= '0;
      txBitCntReg <= '0;
      txOddReg    <= 1'b0;
      rdFrameReg  <= '0;
      leadReg     <= 1'b0;
    end else if (clkEn) begin
      phaseAccReg <= strobeNow ? phaseSum - 16'(CORE_KHZ) : phaseSum;
      if (strobeNow) begin
        txBitCntReg <= txBitCntReg + 8'h01;
        if (txBitCntReg == FRAME_LAST_BIT) begin
          txOddReg <= !txOddReg;
        end
      end
      if (frameStart) begin
        rdFrameReg <= newest;
        if (slipEvent) begin
          leadReg <= newest == rdFrameReg;
        end
      end
    end
  end

  assign oddEff    = {oddTxReg[7], 1'b1, alarmOr, oddTxReg[4:0]};
  assign txSlotVal = txOddReg ? (loopReg ? oddTestReg : oddEff)
                              : (loopReg ? evenTestReg : evenTxReg);
  assign rxSlotVal = txOddReg ? oddTestReg : evenTestReg;
  assign txBitNow  = slot0 ? txSlotVal[~txBitCntReg[2:0]] : txMuxData;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxDataReg <= 1'b0;
    end else if (clkEn && strobeNow) begin
      if (loopReg && slot0) begin
        rxDataReg <= rxSlotVal[~txBitCntReg[2:0]];
      end else begin
        rxDataReg <= frameMem[{rdFrameUse, txBitCntReg}];
      end
    end
  end

  assign localMux = '{rxData: rxDataReg, bitStrobe: strobeNow, frameStart: frameStart};

  pjt_hdb3_encoder u_tx_encoder (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .bitStrobe (strobeNow),
    .hdb3En    (!binMode),
    .dataIn    (txBitNow),
    .railPos   (txRailPositive),
    .railNeg   (txRailNegative)
  );

  // ==========================================================================
  // Register bus slave.
  assign addrPhase  = hsel && hready && htrans == HTRANS_NONSEQ;
  assign statusRead = addrPhase && !hwrite && haddr[7:0] == OFS_STATUS;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign statusVal  = {slipReg, leadReg, excessErrReg, raiReg, desync,
                       clkAbsentReg, alignReg == ALIGN_HUNT, remoteLossReg};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slipReg <= 1'b0;
    end else if (clkEn) begin
      if (slipEvent) begin
        slipReg <= 1'b1;
      end else if (statusRead) begin
        slipReg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPendReg <= 1'b0;
      wrAddrReg <= '0;
      hrdata    <= '0;
    end else if (clkEn) begin
      wrPendReg <= addrPhase && hwrite && cpuMode;
      wrAddrReg <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        hrdata <= '0;
        if (!cpuMode) begin
          hrdata <= '0;
        end else if (haddr[7:0] == OFS_EVEN_TX) begin
          hrdata[7:0] <= evenTxReg;
        end else if (haddr[7:0] == OFS_ODD_TX) begin
          hrdata[7:0] <= oddEff;
        end else if (haddr[7:0] == OFS_EVEN_TEST) begin
          hrdata[7:0] <= evenTestReg;
        end else if (haddr[7:0] == OFS_ODD_TEST) begin
          hrdata[7:0] <= oddTestReg;
        end else if (haddr[7:0] == OFS_STATUS) begin
          hrdata[7:0] <= statusVal;
        end else if (haddr[7:0] == OFS_LOOP) begin
          hrdata[0] <= loopReg;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evenTxReg   <= RST_EVEN_TX;
      oddTxReg    <= RST_ODD_TX;
      evenTestReg <= RST_TEST;
      oddTestReg  <= RST_TEST;
      loopReg     <= 1'b0;
    end else if (clkEn && wrPendReg) begin
      if (wrAddrReg == OFS_EVEN_TX) begin
        evenTxReg[POS_SPARE_BIT] <= hwdata[POS_SPARE_BIT];
      end else if (wrAddrReg == OFS_ODD_TX) begin
        oddTxReg <= {hwdata[7], 2'h3, hwdata[4:0]};
      end else if (wrAddrReg == OFS_EVEN_TEST) begin
        evenTestReg <= hwdata[7:0];
      end else if (wrAddrReg == OFS_ODD_TEST) begin
        oddTestReg <= hwdata[7:0];
      end else if (wrAddrReg == OFS_LOOP) begin
        loopReg <= hwdata[0];
      end
    end
  end

endmodule

//--- sim/pjt_junction_unit_sva.sv
`timescale 1ns/1ps
module pjt_junction_unit_sva import pjt_pkg::*; (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  // Register bus.
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        cpuPortStrap,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Streams.
  input wire logic        txRailPositive,
  input wire pjt_mux_t    localMux
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n || !clkEn);
  logic [11:0] sinceFrame;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sinceFrame <= 12'h000;
    else if (localMux.frameStart) sinceFrame <= 12'h001;
    else if (sinceFrame != 12'h000 && sinceFrame != 12'hfff) sinceFrame <= sinceFrame + 12'h001;
  end
  sequence rdAddr;
    hsel && htrans == HTRANS_NONSEQ && !hwrite;
  endsequence
  sequence rdOdd;
    rdAddr ##0 (haddr[7:0] == OFS_ODD_TX && cpuPortStrap && $past(cpuPortStrap, 3)
      && $past(rst_n, 4));
  endsequence
  sequence rdZero;
    rdAddr ##0 (haddr[7:0] == 8'h18 || (!cpuPortStrap && !$past(cpuPortStrap, 3)));
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_ODD_FIXED: assert property (rdOdd |=> hrdata[POS_ODD_FIXED])
    else $error("odd fixed bit not one");
  AST_READ_ZERO: assert property (rdZero |=> hrdata == 32'h0)
    else $error("refused read not zero");
  AST_STROBE_MIN: assert property (localMux.bitStrobe |=> (!localMux.bitStrobe)[*8])
    else $error("bit strobes too close");
  AST_STROBE_MAX: assert property (localMux.bitStrobe |-> ##[9:10] localMux.bitStrobe)
    else $error("bit strobe late");
  AST_FRAME_STROBE: assert property (localMux.frameStart |-> localMux.bitStrobe)
    else $error("frame start off strobe");
  AST_FRAME_LEN: assert property ((sinceFrame <= 12'h9c8) and
    (localMux.frameStart && sinceFrame != 12'h000 |-> sinceFrame >= 12'h9c0))
    else $error("local frame length wrong");
  AST_TX_TIMING: assert property ($changed(txRailPositive) |-> $past(localMux.bitStrobe))
    else $error("tx changed off strobe");
  AST_RX_TIMING: assert property ($changed(localMux.rxData) |-> $past(localMux.bitStrobe))
    else $error("rx data changed off strobe");
endmodule

bind pjt_junction_unit pjt_junction_unit_sva chk_u (.core_clk, .rst_n, .clkEn, .hsel, .haddr,
  .htrans, .hwrite, .cpuPortStrap, .hreadyout, .hresp, .hrdata, .txRailPositive, .localMux);

//--- sim/pjt_line_model.sv
`timescale 1ns/1ps
module pjt_line_model import pjt_pkg::*; (
  // Controls.
  input  wire logic ra,
  input  wire logic stop,
  // Line pins.
  output pjt_line_t line
);
  logic       clk = 1'b0;
  logic [8:0] bitNum = 9'h000;
  logic [7:0] slot0;
  logic       rxP;
  initial forever begin
    #200;
    if (!stop) clk = ~clk;
  end
  always @(posedge clk) bitNum <= bitNum + 9'h001;
  assign slot0 = bitNum[8] ? {2'b11, ra, 5'h1f} : {1'b1, FAS_WORD};
  assign rxP = (bitNum[7:3] == 5'h00) ? slot0[~bitNum[2:0]] : bitNum[0];
  assign line = '{recoveredRemoteClock: clk, rxRailPositive: rxP, rxRailNegative: ~rxP};
endmodule

//--- sim/pjt_junction_unit_test.sv
`timescale 1ns/1ps
module pjt_junction_unit_test import pjt_pkg::*;;
  logic        core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        strap = 1'b1, ra = 1'b0, stop = 1'b0, bin = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, txP, txN, fp;
  pjt_mux_t    mux;
  pjt_line_t   line;
  int          n_fail = 0, tests_run = 0, cyc = 0;
  pjt_junction_unit dut_u (.core_clk, .rst_n, .clkEn(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .cpuPortStrap(strap), .binaryModeStrap(bin), .lineIn(line), .txRailPositive(txP),
    .txRailNegative(txN), .framePhase4kOut(fp), .txMuxData(1'b0), .localMux(mux));
  pjt_line_model line_u (.ra, .stop, .line);
  initial forever #25 core_clk = ~core_clk;
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic slot(output logic [7:0] v, output logic [7:0] r);
    v = 8'h0;
    r = 8'h0;
    do @(negedge core_clk); while (mux.frameStart !== 1'b1);
    for (int i = 0; i < 8; i++) begin
      if (i > 0)
        do @(negedge core_clk); while (mux.bitStrobe !== 1'b1);
      @(posedge core_clk);
      #1 v = {v[6:0], txP};
      r = {r[6:0], mux.rxData};
    end
    @(posedge core_clk);
  endtask
  task automatic t_tx(input logic [7:0] e, input logic [7:0] o, input logic [7:0] re,
                      input logic [7:0] ro);
    logic [7:0] a, b, x, y;
    slot(a, x);
    slot(b, y);
    if (a === o) begin
      {a, b, x, y} = {b, a, y, x};
    end
    chk(a, e);
    chk(b, o);
    chk({x === re || x === ro, y === re || y === ro}, 32'h3);
  endtask
  task automatic t_phase();
    int n;
    logic p;
    n = 0;
    @(negedge core_clk);
    p = fp;
    do @(negedge core_clk); while (fp === p);
    p = fp;
    do begin
      @(negedge core_clk);
      n++;
    end while (fp === p && n < 5000);
    chk(n, 32'd2048);
    @(posedge core_clk);
  endtask
  task automatic t_hdb3();
    int gap, worst;
    gap = 0;
    worst = 0;
    bin <= 1'b0;
    do @(negedge core_clk); while (mux.frameStart !== 1'b1);
    for (int i = 0; i < 112; i++) begin
      do @(negedge core_clk); while (mux.bitStrobe !== 1'b1);
      @(posedge core_clk);
      #1 gap = (txP || txN) ? 0 : gap + 1;
      if (txP && txN) worst = 99;
      if (i > 24 && gap > worst) worst = gap;
    end
    chk(worst > 3, 32'h0);
  endtask
  task automatic t_regs();
    rdc(OFS_EVEN_TX, 32'h9b);
    rdc(OFS_ODD_TEST, 32'h0);
    rdc(OFS_LOOP, 32'h0);
    wr(OFS_EVEN_TX, 32'h0);
    rdc(OFS_EVEN_TX, 32'h1b);
    wr(OFS_ODD_TX, 32'h0);
    rdc(OFS_ODD_TX, 32'h60);
    wr(OFS_EVEN_TEST, 32'ha5);
    wr(OFS_ODD_TEST, 32'h5a);
    rdc(OFS_EVEN_TEST, 32'ha5);
    rdc(OFS_ODD_TEST, 32'h5a);
    wr(OFS_LOOP, 32'hff);
    rdc(OFS_LOOP, 32'h1);
    rdc(8'h18, 32'h0);
  endtask
  task automatic t_lock();
    wt(16000);
    rdc(OFS_STATUS, 32'h80);
    wr(OFS_STATUS, 32'hff);
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_ODD_TX, 32'h40);
  endtask
  task automatic t_alarms();
    ra <= 1'b1;
    wt(6000);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    ra <= 1'b0;
    stop <= 1'b1;
    wt(60);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    rdc(OFS_ODD_TX, 32'h60);
    stop <= 1'b0;
    wt(6000);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'hf, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    wt(4);
    t_regs();
    t_tx(8'ha5, 8'h5a, 8'ha5, 8'h5a);
    t_lock();
    t_phase();
    wr(OFS_LOOP, 32'h0);
    t_tx(8'h1b, 8'h40, {1'b1, FAS_WORD}, 8'hdf);
    t_alarms();
    t_hdb3();
    strap <= 1'b0;
    wt(4);
    rdc(OFS_EVEN_TEST, 32'h0);
    end_sim();
  end
endmodule
